//--- scw_core.sv
// Self-test control, status flags, user mirror writes and OTP unlock control
//
// Notes on behaviour
// - Buffer supply low sets flag; status read clears.
// - Bus input low sets flag; status read clears.
// - Nonzero pattern select forces fixed result values.
// - Zero pattern select lets processor update results.
// - Periodic mode entry clears both pattern selects.
// - Check enable drives self-test; periodic mode entry clears.
// - Not-run flag set at reset; cleared by enable write.
// - Periodic mode before check keeps not-run while the mode lasts.
// - Enable plus pattern: pattern forced, check still runs.
// - User array writes touch mirrors only until unlock.
// - Three exact consecutive unlock writes start OTP copy.
// - Sequence 01,11,10 copies without physical address.
// - Check-active status is OR of three control bits.
// - Lock blocks array and mirror writes except address.
`timescale 1ns/10ps
module scw_core (
    input  wire logic             CORE_CLK,
    input  wire logic             RST_N,
    input  wire scw_pkg::scw_cmd_t CMD,
    input  wire logic             PERIODIC_COLLECTION_MODE,
    input  wire logic             BUFFER_SUPPLY_LOW,
    input  wire logic             BUS_INPUT_LOW,
    input  wire logic [15:0]      DSP_RESULT,
    input  wire logic             DSP_RESULT_VALID,
    input  wire logic             PHYS_ASSIGNED,
    input  wire logic             LOCK_PROGRAMMED,
    output logic [7:0]            RDATA,
    output logic [7:0]            ACCEL_RESULT_HIGH,
    output logic [7:0]            ACCEL_RESULT_LOW,
    output logic                  TRANSDUCER_CHECK,
    output logic                  CHECK_ACTIVE_FLAG,
    output logic                  CHECK_NOT_RUN_FLAG,
    output logic                  MIRROR_WE,
    output logic [7:0]            MIRROR_ADDR,
    output logic [7:0]            MIRROR_WDATA,
    output logic                  OTP_COPY_START,
    output logic                  OTP_COPY_WITH_PHYS
);
    // ------------------------------------------------------------------
    // Local state
    // ------------------------------------------------------------------
    logic [2:0]            ctrl_q;
    logic                  buffer_low_q;
    logic                  bus_low_q;
    logic                  not_run_q;
    logic                  periodic_q;
    logic [7:0]            unlock_q;
    logic                  rd_stat2;
    logic                  wr_ctrl;
    logic                  periodic_rise;
    logic [1:0]            pattern_sel;
    scw_pkg::scw_otp_req_t otp_req;

    // Classify a command by register address
    function automatic logic hits(input scw_pkg::scw_cmd_t c, input logic [7:0] a);
        hits = c.valid && (c.addr == a);
    endfunction

    assign rd_stat2      = hits(CMD, scw_pkg::DEVICE_STATUS_TWO) && !CMD.write;
    assign wr_ctrl       = hits(CMD, scw_pkg::SELF_CHECK_CONTROL) && CMD.write;
    assign periodic_rise = PERIODIC_COLLECTION_MODE && !periodic_q;
    assign pattern_sel   = {ctrl_q[scw_pkg::PATTERN_TEN_BIT], ctrl_q[scw_pkg::PATTERN_FIVE_BIT]};

    // ------------------------------------------------------------------
    // Periodic mode edge detect
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            periodic_q <= 1'b0;
        end else begin
            periodic_q <= PERIODIC_COLLECTION_MODE;
        end
    end

    // ------------------------------------------------------------------
    // Self-check control register; mode entry wins over a write
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q <= scw_pkg::SELF_CHECK_RESET;
        end else if (periodic_rise) begin
            ctrl_q <= scw_pkg::SELF_CHECK_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= CMD.wdata[2:0];
        end
    end

    // ------------------------------------------------------------------
    // Clear-on-read supply flags; a new event beats the read clear
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            buffer_low_q <= 1'b0;
            bus_low_q    <= 1'b0;
        end else begin
            buffer_low_q <= BUFFER_SUPPLY_LOW || (buffer_low_q && !rd_stat2);
            bus_low_q    <= BUS_INPUT_LOW || (bus_low_q && !rd_stat2);
        end
    end

    // ------------------------------------------------------------------
    // Not-run flag: set at reset, cleared only by enabling the check
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            not_run_q <= 1'b1;
        end else if (wr_ctrl && CMD.wdata[scw_pkg::TRANSDUCER_CHECK_BIT]
                     && !periodic_rise && !PERIODIC_COLLECTION_MODE) begin
            not_run_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Result registers: forced pattern or processor update
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ACCEL_RESULT_HIGH <= 8'h00;
            ACCEL_RESULT_LOW  <= 8'h00;
        end else begin
            case (pattern_sel)
                2'h1: {ACCEL_RESULT_HIGH, ACCEL_RESULT_LOW} <= scw_pkg::PATTERN_FIVE;
                2'h2: {ACCEL_RESULT_HIGH, ACCEL_RESULT_LOW} <= scw_pkg::PATTERN_TEN;
                2'h3: {ACCEL_RESULT_HIGH, ACCEL_RESULT_LOW} <= scw_pkg::PATTERN_ALL;
                default: begin
                    if (DSP_RESULT_VALID) begin
                        {ACCEL_RESULT_HIGH, ACCEL_RESULT_LOW} <= DSP_RESULT;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            TRANSDUCER_CHECK   <= 1'b0;
            CHECK_ACTIVE_FLAG  <= 1'b0;
            CHECK_NOT_RUN_FLAG <= 1'b1;
        end else begin
            TRANSDUCER_CHECK   <= ctrl_q[scw_pkg::TRANSDUCER_CHECK_BIT];
            CHECK_ACTIVE_FLAG  <= |ctrl_q;
            CHECK_NOT_RUN_FLAG <= not_run_q;
        end
    end

    // ------------------------------------------------------------------
    // Unlock register storage and user mirror writes
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            unlock_q     <= 8'h00;
            MIRROR_WE    <= 1'b0;
            MIRROR_ADDR  <= 8'h00;
            MIRROR_WDATA <= 8'h00;
        end else begin
            MIRROR_WE <= 1'b0;
            if (CMD.valid && CMD.write && CMD.addr == scw_pkg::NVM_WRITE_UNLOCK) begin
                unlock_q <= {6'h00, CMD.wdata[1:0]};
            end
            if (CMD.valid && CMD.write && CMD.addr >= scw_pkg::USER_ARRAY_LO
                && CMD.addr <= scw_pkg::USER_ARRAY_HI
                && (!LOCK_PROGRAMMED || CMD.addr == scw_pkg::USER_ARRAY_LO)) begin
                MIRROR_WE    <= 1'b1;
                MIRROR_ADDR  <= CMD.addr;
                MIRROR_WDATA <= CMD.wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read data mux
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= 8'h00;
        end else if (CMD.valid && !CMD.write) begin
            if (CMD.addr == scw_pkg::DEVICE_STATUS_TWO) begin
                RDATA <= {5'h00, not_run_q, buffer_low_q, bus_low_q};
            end else if (CMD.addr == scw_pkg::SELF_CHECK_CONTROL) begin
                RDATA <= {5'h00, ctrl_q};
            end else if (CMD.addr == scw_pkg::NVM_WRITE_UNLOCK) begin
                RDATA <= unlock_q;
            end else begin
                RDATA <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------------
    // Unlock sequence detector
    // ------------------------------------------------------------------
    scw_unlock u_unlock (
        .clk           (CORE_CLK),
        .rst_n         (RST_N),
        .cmd           (CMD),
        .phys_assigned (PHYS_ASSIGNED),
        .otp_req       (otp_req)
    );

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            OTP_COPY_START     <= 1'b0;
            OTP_COPY_WITH_PHYS <= 1'b0;
        end else begin
            OTP_COPY_START     <= otp_req.start;
            OTP_COPY_WITH_PHYS <= otp_req.with_phys;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_flag_read_clr: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        rd_stat2 && !BUFFER_SUPPLY_LOW |=> !buffer_low_q)
        else $error("Buffer flag not cleared by read");
    a_bus_flag_set: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        BUS_INPUT_LOW |=> bus_low_q)
        else $error("Bus input flag not set");
    a_pattern_five: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        pattern_sel == 2'h1 |=> {ACCEL_RESULT_HIGH, ACCEL_RESULT_LOW} == 16'h5555)
        else $error("Pattern five not forced");
    a_dsp_update: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        pattern_sel == 2'h0 && DSP_RESULT_VALID |=> {ACCEL_RESULT_HIGH, ACCEL_RESULT_LOW}
        == $past(DSP_RESULT))
        else $error("Processor result not taken");
    a_periodic_clear: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        periodic_rise |=> ctrl_q == 3'h0 ##1 !TRANSDUCER_CHECK)
        else $error("Periodic entry did not clear controls");
    a_not_run_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        not_run_q && !(wr_ctrl && CMD.wdata[0]) |=> not_run_q)
        else $error("Not-run flag cleared without enable write");
    a_active_or: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        ##1 CHECK_ACTIVE_FLAG == |$past(ctrl_q))
        else $error("Active flag not OR of controls");
    a_lock_blocks: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        MIRROR_WE && $past(LOCK_PROGRAMMED) |-> MIRROR_ADDR == scw_pkg::USER_ARRAY_LO)
        else $error("Locked array mirror written");
endmodule

//--- scw_pkg.sv
// Package: register offsets, field positions, reset values and shared types
package scw_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] LOCK_REGISTER_ADDR   = 8'h20;
    localparam logic [7:0] DEVICE_STATUS_TWO    = 8'h22;
    localparam logic [7:0] SELF_CHECK_CONTROL   = 8'h23;
    localparam logic [7:0] NVM_WRITE_UNLOCK     = 8'h24;
    localparam logic [7:0] USER_ARRAY_LO        = 8'h10;
    localparam logic [7:0] USER_ARRAY_HI        = 8'h20;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int TRANSDUCER_CHECK_BIT = 0;
    localparam int PATTERN_TEN_BIT      = 1;
    localparam int PATTERN_FIVE_BIT     = 2;
    localparam int LOCK_BIT             = 7;
    localparam int CHECK_NOT_RUN_BIT    = 2;
    localparam int BUFFER_LOW_BIT       = 1;
    localparam int BUS_INPUT_LOW_BIT    = 0;
    localparam logic [2:0] SELF_CHECK_RESET = 3'h0;
    localparam logic [15:0] PATTERN_FIVE  = 16'h5555;
    localparam logic [15:0] PATTERN_TEN   = 16'hAAAA;
    localparam logic [15:0] PATTERN_ALL   = 16'hFFFF;

    // Unlock sequence values (whole register, upper bits zero)
    localparam logic [7:0] UNLOCK_INC_1 = 8'h02;
    localparam logic [7:0] UNLOCK_INC_2 = 8'h03;
    localparam logic [7:0] UNLOCK_INC_3 = 8'h01;
    localparam logic [7:0] UNLOCK_EXC_1 = 8'h01;
    localparam logic [7:0] UNLOCK_EXC_2 = 8'h03;
    localparam logic [7:0] UNLOCK_EXC_3 = 8'h02;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_ONE, SEQ_TWO} scw_seq_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } scw_cmd_t;

    typedef struct packed {
        logic start;
        logic with_phys;
    } scw_otp_req_t;

endpackage

//--- scw_unlock.sv
// Three-write unlock sequence detector for the OTP copy
`timescale 1ns/10ps
module scw_unlock (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire scw_pkg::scw_cmd_t cmd,
    input  wire logic             phys_assigned,
    output scw_pkg::scw_otp_req_t otp_req
);
    scw_pkg::scw_seq_t state_q;
    logic              inc_path_q;
    logic              is_unlock;

    assign is_unlock = cmd.write && (cmd.addr == scw_pkg::NVM_WRITE_UNLOCK);

    // Sequence tracking; any other command restarts it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= scw_pkg::SEQ_IDLE;
            inc_path_q <= 1'b0;
            otp_req    <= '0;
        end else begin
            otp_req <= '0;
            if (cmd.valid) begin
                state_q <= scw_pkg::SEQ_IDLE;
                case (state_q)
                    scw_pkg::SEQ_IDLE: begin
                        if (is_unlock && cmd.wdata == scw_pkg::UNLOCK_INC_1) begin
                            state_q    <= scw_pkg::SEQ_ONE;
                            inc_path_q <= 1'b1;
                        end else if (is_unlock && cmd.wdata == scw_pkg::UNLOCK_EXC_1) begin
                            state_q    <= scw_pkg::SEQ_ONE;
                            inc_path_q <= 1'b0;
                        end
                    end
                    scw_pkg::SEQ_ONE: begin
                        if (is_unlock && cmd.wdata == scw_pkg::UNLOCK_INC_2) begin
                            state_q <= scw_pkg::SEQ_TWO;
                        end
                    end
                    scw_pkg::SEQ_TWO: begin
                        if (is_unlock && inc_path_q
                            && cmd.wdata == scw_pkg::UNLOCK_INC_3) begin
                            otp_req.start     <= 1'b1;
                            otp_req.with_phys <= phys_assigned;
                        end else if (is_unlock && !inc_path_q
                            && cmd.wdata == scw_pkg::UNLOCK_EXC_3) begin
                            otp_req.start     <= 1'b1;
                            otp_req.with_phys <= 1'b0;
                        end
                    end
                    default: state_q <= scw_pkg::SEQ_IDLE;
                endcase
            end
        end
    end

    // Copy only after a full matching sequence
    a_otp_start_seq: assert property (@(posedge clk) disable iff (!rst_n)
        otp_req.start |-> $past(state_q) == scw_pkg::SEQ_TWO && $past(is_unlock))
        else $error("OTP copy started without full unlock sequence");
    a_exclude_phys: assert property (@(posedge clk) disable iff (!rst_n)
        otp_req.start && !$past(inc_path_q) |-> !otp_req.with_phys)
        else $error("Exclusion sequence copied physical address");
endmodule

//--- scw_master.sv
// Bus master model issuing decoded command-and-response transfers to the core
`timescale 1ns/10ps
module scw_master #(
    parameter int NVM_WAIT = 40
) (
    input  wire logic        clk,
    output scw_pkg::scw_cmd_t cmd
);
    // ------------------------------------------------------------------
    // Command issue
    // ------------------------------------------------------------------
    // Port idle at time zero
    initial begin
        cmd = '0;
    end

    // One command taken at the next edge, then gap idle edges; gap 0 keeps valid up
    task automatic send(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        input int gap);
        cmd = {1'b1, wr, a, d};
        @(posedge clk);
        #1;
        if (gap > 0) begin
            cmd = {1'b0, wr, ~a, ~d};  // Released address and data lines carry the inverse, not stale data
            repeat (gap) begin
                @(posedge clk);
                #1;
            end
        end
    endtask

    // ------------------------------------------------------------------
    // User array programming procedure
    // ------------------------------------------------------------------
    // Values, lock, unlock sequence, wait, then read back every user register
    task automatic program_nvm(input logic incl, input logic [7:0] phys);
        logic [7:0] v1, v2, v3;
        v1 = incl ? scw_pkg::UNLOCK_INC_1 : scw_pkg::UNLOCK_EXC_1;
        v2 = incl ? scw_pkg::UNLOCK_INC_2 : scw_pkg::UNLOCK_EXC_2;
        v3 = incl ? scw_pkg::UNLOCK_INC_3 : scw_pkg::UNLOCK_EXC_3;
        send(1'b1, scw_pkg::USER_ARRAY_LO, incl ? phys : 8'h00, 1);
        send(1'b1, 8'h11, 8'h3C, 1);
        send(1'b1, scw_pkg::LOCK_REGISTER_ADDR, 8'h80, 1);
        send(1'b1, scw_pkg::NVM_WRITE_UNLOCK, v1, 0);
        send(1'b1, scw_pkg::NVM_WRITE_UNLOCK, v2, 0);
        send(1'b1, scw_pkg::NVM_WRITE_UNLOCK, v3, 1);
        repeat (NVM_WAIT) @(posedge clk);
        #1;
        for (int i = 16; i <= 32; i++) begin
            send(1'b0, i[7:0], 8'h00, 1);
        end
    endtask
endmodule

//--- scw_core_tb_top.sv
// Self-checking bench for the self-test control and OTP unlock core
`timescale 1ns/10ps
module scw_core_tb_top;
    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    logic              clk, rst_n, periodic_collection_mode, buf_low, bus_low, dsp_vld, phys, lock;
    logic              chk_on, act, not_run, mwe, otp_go, otp_ph, otp_ph_seen;
    logic [15:0]       dsp;
    logic [7:0]        rdata, acc_h, acc_l, ma, md, last_ma, last_md;
    scw_pkg::scw_cmd_t cmd;
    int                n_fail, check_count, n_mwe, n_otp, cycles;

    scw_master #(.NVM_WAIT(40)) u_m (.clk(clk), .cmd(cmd));

    scw_core dut (
        .CORE_CLK(clk), .RST_N(rst_n), .CMD(cmd), .PERIODIC_COLLECTION_MODE(periodic_collection_mode),
        .BUFFER_SUPPLY_LOW(buf_low), .BUS_INPUT_LOW(bus_low), .DSP_RESULT(dsp),
        .DSP_RESULT_VALID(dsp_vld), .PHYS_ASSIGNED(phys), .LOCK_PROGRAMMED(lock),
        .RDATA(rdata), .ACCEL_RESULT_HIGH(acc_h), .ACCEL_RESULT_LOW(acc_l),
        .TRANSDUCER_CHECK(chk_on), .CHECK_ACTIVE_FLAG(act), .CHECK_NOT_RUN_FLAG(not_run),
        .MIRROR_WE(mwe), .MIRROR_ADDR(ma), .MIRROR_WDATA(md),
        .OTP_COPY_START(otp_go), .OTP_COPY_WITH_PHYS(otp_ph)
    );

    // Clock at 50 MHz
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Pulse monitors and hang guard, sampled mid-cycle away from the launching edge
    always @(negedge clk) begin
        cycles++;
        if (mwe === 1'b1) begin
            n_mwe++;
            last_ma = ma;
            last_md = md;
        end
        if (otp_go === 1'b1) begin
            n_otp++;
            otp_ph_seen = otp_ph;
        end
        if (cycles == 3000) begin
            n_fail++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------------
    // Helpers and compares
    // ------------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t reg got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t word got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t bit got %h exp %h", $time, got, exp);
        end
    endtask

    // Register read with the answer judged one cycle after the take edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        u_m.send(1'b0, a, 8'h00, 1);
        chk_reg(rdata, exp);
    endtask

    task automatic report_and_stop;
        $display("TB: checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        chk_bit(not_run, 1'b1);
        rd(scw_pkg::DEVICE_STATUS_TWO, 8'h04);
        rd(scw_pkg::SELF_CHECK_CONTROL, 8'h00);
        $display("test reset done");
    endtask

    // Each supply event sets its flag; a status read clears it
    task automatic t_flags;
        buf_low = 1'b1;
        step(1);
        buf_low = 1'b0;
        step(2);
        rd(scw_pkg::DEVICE_STATUS_TWO, 8'h06);
        rd(scw_pkg::DEVICE_STATUS_TWO, 8'h04);
        bus_low = 1'b1;
        step(1);
        bus_low = 1'b0;
        step(2);
        rd(scw_pkg::DEVICE_STATUS_TWO, 8'h05);
        rd(scw_pkg::DEVICE_STATUS_TWO, 8'h04);
        $display("test flags done");
    endtask

    // Every pattern select, reserved bits written high, then select cleared again
    task automatic t_patterns;
        logic [1:0]  sel;
        logic [15:0] exp;
        for (int s = 0; s < 5; s++) begin
            sel = s[1:0];
            dsp = 16'h1230 + 16'(s);
            exp = (sel == 2'h0) ? dsp : (sel == 2'h1) ? 16'h5555 :
                  (sel == 2'h2) ? 16'hAAAA : 16'hFFFF;
            u_m.send(1'b1, scw_pkg::SELF_CHECK_CONTROL, {5'h1F, sel[0], sel[1], 1'b0}, 1);
            rd(scw_pkg::SELF_CHECK_CONTROL, {5'h00, sel[0], sel[1], 1'b0});
            dsp_vld = 1'b1;
            step(1);
            dsp_vld = 1'b0;
            step(2);
            chk_word({acc_h, acc_l}, exp);
            chk_bit(act, sel != 2'h0);
        end
        $display("test patterns done");
    endtask

    // Check plus pattern together, then periodic entry clears the control bits
    task automatic t_transducer_check_enable;
        u_m.send(1'b1, scw_pkg::SELF_CHECK_CONTROL, 8'h03, 1);
        step(1);
        chk_bit(chk_on, 1'b1);
        step(1);
        chk_word({acc_h, acc_l}, 16'hAAAA);
        rd(scw_pkg::DEVICE_STATUS_TWO, 8'h00);
        periodic_collection_mode = 1'b1;
        step(2);
        rd(scw_pkg::SELF_CHECK_CONTROL, 8'h00);
        chk_bit(chk_on, 1'b0);
        chk_bit(act, 1'b0);
        periodic_collection_mode = 1'b0;
        step(1);
        $display("test transducer_check_enable done");
    endtask

    // Second reset, periodic mode entered before any self-test
    task automatic t_periodic_collection_mode_first;
        rst_n = 1'b0;
        step(2);
        rst_n = 1'b1;
        step(1);
        chk_bit(not_run, 1'b1);
        periodic_collection_mode = 1'b1;
        step(2);
        u_m.send(1'b1, scw_pkg::SELF_CHECK_CONTROL, 8'h01, 2);
        rd(scw_pkg::DEVICE_STATUS_TWO, 8'h04);
        periodic_collection_mode = 1'b0;
        u_m.send(1'b1, scw_pkg::SELF_CHECK_CONTROL, 8'h00, 2);
        $display("test periodic first done");
    endtask

    // Mirror writes only, and lock leaves the address mirror writable
    task automatic t_mirror;
        int b;
        int o;
        b = n_mwe;
        o = n_otp;
        u_m.send(1'b1, 8'h15, 8'h5A, 2);
        chk_reg(8'(n_mwe - b), 8'h01);
        chk_reg(last_md, 8'h5A);
        chk_reg(8'(n_otp - o), 8'h00);
        lock = 1'b1;
        u_m.send(1'b1, 8'h15, 8'hA5, 1);
        u_m.send(1'b1, scw_pkg::USER_ARRAY_LO, 8'h07, 2);
        chk_reg(8'(n_mwe - b), 8'h02);
        chk_reg(last_ma, scw_pkg::USER_ARRAY_LO);
        lock = 1'b0;
        $display("test mirror done");
    endtask

    // Both unlock sequences, then interrupted and mismatched ones
    task automatic t_unlock;
        int o;
        o = n_otp;
        phys = 1'b1;
        u_m.program_nvm(1'b1, 8'h07);
        chk_reg(8'(n_otp - o), 8'h01);
        chk_bit(otp_ph_seen, 1'b1);
        phys = 1'b0;
        u_m.program_nvm(1'b1, 8'h07);
        chk_bit(otp_ph_seen, 1'b0);
        phys = 1'b1;
        u_m.program_nvm(1'b0, 8'h00);
        chk_reg(8'(n_otp - o), 8'h03);
        chk_bit(otp_ph_seen, 1'b0);
        u_m.send(1'b1, scw_pkg::NVM_WRITE_UNLOCK, 8'h02, 0);
        u_m.send(1'b1, scw_pkg::NVM_WRITE_UNLOCK, 8'h03, 0);
        u_m.send(1'b0, scw_pkg::SELF_CHECK_CONTROL, 8'h00, 0);
        u_m.send(1'b1, scw_pkg::NVM_WRITE_UNLOCK, 8'h01, 0);
        u_m.send(1'b1, scw_pkg::NVM_WRITE_UNLOCK, 8'h01, 0);
        u_m.send(1'b1, scw_pkg::NVM_WRITE_UNLOCK, 8'h01, 0);
        u_m.send(1'b1, scw_pkg::NVM_WRITE_UNLOCK, 8'h03, 0);
        u_m.send(1'b1, scw_pkg::NVM_WRITE_UNLOCK, 8'h06, 4);
        chk_reg(8'(n_otp - o), 8'h03);
        u_m.send(1'b1, scw_pkg::NVM_WRITE_UNLOCK, 8'h01, 0);
        u_m.send(1'b1, scw_pkg::NVM_WRITE_UNLOCK, 8'h03, 0);
        u_m.send(1'b1, scw_pkg::NVM_WRITE_UNLOCK, 8'h02, 4);
        chk_reg(8'(n_otp - o), 8'h04);
        rd(scw_pkg::NVM_WRITE_UNLOCK, 8'h02);
        $display("test unlock done");
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst_n, periodic_collection_mode, buf_low, bus_low, dsp_vld, phys, lock} = '0;
        dsp = 16'h0000;
        {n_fail, check_count, n_mwe, n_otp, cycles} = '0;
        {last_ma, last_md, otp_ph_seen} = '0;
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_flags();
        t_patterns();
        t_transducer_check_enable();
        t_periodic_collection_mode_first();
        t_mirror();
        t_unlock();
        report_and_stop();
    end
endmodule
